// ### core/switch_global_control_pkg.sv
package switch_global_control_pkg;

  // register byte addresses (apb word per register)
  localparam logic [11:0] ADDR_GLOBAL_CONTROL_ZERO_LOW = 12'h008;
  localparam logic [11:0] ADDR_GLOBAL_CONTROL_ONE      = 12'h00C;
  localparam logic [11:0] ADDR_STATUS                  = 12'h010;

  // global_control_zero_low field positions
  localparam int BIT_PURGE      = 4;
  localparam int BIT_RSVD3      = 3;
  localparam int BIT_RSVD2      = 2;
  localparam int BIT_CONF_DROP  = 1;
  localparam int BIT_LINK_AGE   = 0;

  // global_control_one field positions
  localparam int BIT_LONG_FRAME = 6;
  localparam int BIT_TX_PAUSE   = 5;
  localparam int BIT_RX_PAUSE   = 4;
  localparam int BIT_LEN_CHECK  = 3;
  localparam int BIT_AGE_EN     = 2;
  localparam int BIT_FAST_AGE   = 1;
  localparam int BIT_AGGR_BO    = 0;

  // reset values (pause bits come from the strap)
  localparam logic [7:0] RESET_ZERO_LOW = 8'h0C;
  localparam logic [7:0] RESET_ONE      = 8'h04;

  // frame classification constants
  localparam logic [15:0] PAUSE_TYPE     = 16'h8808;
  localparam logic [47:0] PAUSE_DA       = 48'h0180C2000001;
  localparam logic [15:0] MAX_LEN_FIELD  = 16'h05DC;
  localparam logic [15:0] STD_MAX_LEN    = 16'h05EE;
  localparam logic [15:0] LONG_MAX_LEN   = 16'h0800;

  // aging periods
  localparam longint FAST_AGE_US        = 800;
  localparam longint NORMAL_AGE_S       = 300;
  localparam longint CLK_MHZ            = 100;
  localparam longint FAST_AGE_CYCLES    = FAST_AGE_US * CLK_MHZ - 1;
  localparam longint NORMAL_AGE_CYCLES  = NORMAL_AGE_S * 1000000 * CLK_MHZ;

  localparam int NUM_PORTS    = 5;
  localparam int TABLE_DEPTH  = 32;
  localparam int IDX_W        = 5;

endpackage

// ### core/static_table_purge_engine.sv
`timescale 1ns/1ps
module static_table_purge_engine
  import switch_global_control_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire logic [NUM_PORTS-1:0]  learn_disable,
  input  wire logic                  entry_valid,
  input  wire logic [NUM_PORTS-1:0]  entry_ports,
  input  wire logic                  entry_multicast,
  output logic      [IDX_W-1:0]      entry_index,
  output logic                       entry_clear,
  output logic                       busy
);

  logic                 single_port;
  logic                 port_no_learn;
  logic                 match;
  logic                 last;

  assign single_port   = (entry_ports != '0) && ((entry_ports & (entry_ports - 1'b1)) == '0);
  assign port_no_learn = |(entry_ports & learn_disable);
  assign match         = entry_valid && single_port && !entry_multicast && port_no_learn;
  assign last          = (entry_index == IDX_W'(TABLE_DEPTH - 1));

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy        <= 1'b0;
      entry_index <= '0;
      entry_clear <= 1'b0;
    end else begin
      entry_clear <= busy && match;
      if (!busy && start) begin
        busy        <= 1'b1;
        entry_index <= '0;
      end else if (busy) begin
        entry_index <= last ? '0 : entry_index + 1'b1;
        busy        <= !last;
      end
    end
  end

endmodule

// ### core/switch_global_control.sv
`timescale 1ns/1ps
module switch_global_control
  import switch_global_control_pkg::*;
#(
  parameter longint NORMAL_AGE = NORMAL_AGE_CYCLES,
  parameter longint FAST_AGE   = FAST_AGE_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  pause_strap,
  input  wire logic [NUM_PORTS-1:0]  link_up,
  input  wire logic [NUM_PORTS-1:0]  an_tx_pause,
  input  wire logic [NUM_PORTS-1:0]  an_rx_pause,
  input  wire logic [NUM_PORTS-1:0]  learn_disable,
  input  wire logic                  frame_valid,
  input  wire logic [47:0]           frame_da,
  input  wire logic [15:0]           frame_type_len,
  input  wire logic [15:0]           frame_payload_len,
  input  wire logic [15:0]           frame_total_len,
  input  wire logic                  frame_is_pause,
  input  wire logic                  entry_valid,
  input  wire logic [NUM_PORTS-1:0]  entry_ports,
  input  wire logic                  entry_multicast,
  output logic      [IDX_W-1:0]      entry_index,
  output logic                       entry_clear,
  output logic                       frame_drop,
  output logic      [NUM_PORTS-1:0]  tx_pause_en,
  output logic      [NUM_PORTS-1:0]  rx_pause_en,
  output logic                       aggressive_backoff,
  output logic                       age_tick,
  output logic                       age_all
);

  typedef enum logic [2:0] {
    AGE_OFF    = 3'b001,
    AGE_NORMAL = 3'b010,
    AGE_FAST   = 3'b100
  } age_state_e;

  logic [7:0]            zero_low;
  logic [7:0]            ctrl_one;
  logic                  strap_s1;
  logic                  strap_s2;
  logic                  strap_loaded;
  logic [NUM_PORTS-1:0]  link_s1;
  logic [NUM_PORTS-1:0]  link_s2;
  logic [NUM_PORTS-1:0]  link_prev;
  logic                  link_lost_pend;
  logic                  one_shot;
  logic [39:0]           age_cnt;
  age_state_e            age_state;
  age_state_e            next_age_state;
  logic                  purge_busy;
  logic                  purge_start;
  logic [IDX_W-1:0]      purge_index;
  logic                  purge_clear;

  wire                   wr_access  = psel && penable && pwrite;
  wire                   rd_access  = psel && penable && !pwrite;
  wire                   sel_zero   = (paddr == ADDR_GLOBAL_CONTROL_ZERO_LOW);
  wire                   sel_one    = (paddr == ADDR_GLOBAL_CONTROL_ONE);
  wire                   sel_stat   = (paddr == ADDR_STATUS);
  wire                   mapped     = sel_zero || sel_one || sel_stat;
  wire                   wr_zero    = wr_access && sel_zero;
  wire                   wr_one     = wr_access && sel_one;
  wire                   conf_drop  = zero_low[BIT_CONF_DROP];
  wire                   link_age   = zero_low[BIT_LINK_AGE];
  wire                   long_frame = ctrl_one[BIT_LONG_FRAME];
  wire                   tx_off     = ctrl_one[BIT_TX_PAUSE];
  wire                   rx_off     = ctrl_one[BIT_RX_PAUSE];
  wire                   len_check  = ctrl_one[BIT_LEN_CHECK];
  wire                   age_en     = ctrl_one[BIT_AGE_EN];
  wire                   fast_age   = ctrl_one[BIT_FAST_AGE];
  wire [NUM_PORTS-1:0]   link_fell  = link_prev & ~link_s2;
  wire [7:0]             zero_rd    = {3'b000, purge_busy, zero_low[3:0]};
  wire [7:0]             stat_rd    = {5'b00000, one_shot, age_state == AGE_FAST, purge_busy};
  wire [31:0]            rd_mux     = sel_zero ? {24'h000000, zero_rd} :
                                      sel_one  ? {24'h000000, ctrl_one} :
                                      sel_stat ? {24'h000000, stat_rd} : 32'h00000000;

  assign purge_start = wr_zero && pwdata[BIT_PURGE] && !purge_busy;

  wire conf_hit  = (frame_type_len == PAUSE_TYPE) || (frame_da == PAUSE_DA);
  wire drop_flow = conf_drop ? conf_hit : frame_is_pause;
  wire drop_len  = len_check && (frame_type_len < MAX_LEN_FIELD)
                   && (frame_type_len != frame_payload_len);
  wire drop_size = frame_total_len > (long_frame ? LONG_MAX_LEN : STD_MAX_LEN);

  wire [39:0] period   = (age_state == AGE_FAST) ? 40'(FAST_AGE) : 40'(NORMAL_AGE);
  wire        cnt_done = (age_cnt >= period);

  static_table_purge_engine u_purge (
    .mclk            (mclk),
    .reset           (reset),
    .start           (purge_start),
    .learn_disable   (learn_disable),
    .entry_valid     (entry_valid),
    .entry_ports     (entry_ports),
    .entry_multicast (entry_multicast),
    .entry_index     (purge_index),
    .entry_clear     (purge_clear),
    .busy            (purge_busy)
  );

  // apb slave, zero wait state
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
    end
  end

  // strap synchroniser runs through reset so the first load sees the pin
  always_ff @(posedge mclk) begin
    strap_s1 <= pause_strap;
    strap_s2 <= strap_s1;
  end

  // synchronisers for pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      link_s1   <= '0;
      link_s2   <= '0;
      link_prev <= '0;
    end else begin
      link_s1   <= link_up;
      link_s2   <= link_s1;
      link_prev <= link_s2;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      zero_low     <= RESET_ZERO_LOW;
      ctrl_one     <= RESET_ONE;
      strap_loaded <= 1'b0;
    end else begin
      strap_loaded <= 1'b1;
      if (wr_zero) begin
        zero_low[BIT_CONF_DROP] <= pwdata[BIT_CONF_DROP];
        zero_low[BIT_LINK_AGE]  <= pwdata[BIT_LINK_AGE];
      end
      if (wr_one) begin
        ctrl_one[7]   <= 1'b0;
        ctrl_one[6:0] <= pwdata[6:0];
      end else if (!strap_loaded) begin
        ctrl_one[BIT_TX_PAUSE] <= strap_s2;
        ctrl_one[BIT_RX_PAUSE] <= strap_s2;
      end
    end
  end

  // aging state machine
  always_comb begin
    next_age_state = age_state;
    unique case (age_state)
      AGE_OFF:    if (age_en) next_age_state = AGE_NORMAL;
      AGE_NORMAL: if (!age_en) next_age_state = AGE_OFF;
                  else if (fast_age || link_lost_pend) next_age_state = AGE_FAST;
      AGE_FAST:   if (!age_en) next_age_state = AGE_OFF;
                  else if (cnt_done && !fast_age) next_age_state = AGE_NORMAL;
      default:    next_age_state = AGE_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      age_state      <= AGE_OFF;
      age_cnt        <= '0;
      link_lost_pend <= 1'b0;
      one_shot       <= 1'b0;
    end else begin
      age_state <= next_age_state;
      age_cnt   <= (cnt_done || next_age_state != age_state) ? '0 : age_cnt + 1'b1;
      if (link_age && |link_fell) begin
        link_lost_pend <= 1'b1;
      end else if (age_state == AGE_FAST) begin
        link_lost_pend <= 1'b0;
      end
      if (age_state == AGE_NORMAL && next_age_state == AGE_FAST && link_lost_pend) begin
        one_shot <= 1'b1;
      end else if (age_state == AGE_FAST && cnt_done) begin
        one_shot <= 1'b0;
      end
    end
  end

  // outputs from flip-flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_drop         <= 1'b0;
      tx_pause_en        <= '0;
      rx_pause_en        <= '0;
      aggressive_backoff <= 1'b0;
      age_tick           <= 1'b0;
      age_all            <= 1'b0;
      entry_index        <= '0;
      entry_clear        <= 1'b0;
    end else begin
      frame_drop         <= frame_valid && (drop_flow || drop_len || drop_size);
      tx_pause_en        <= tx_off ? '0 : an_tx_pause;
      rx_pause_en        <= rx_off ? '0 : an_rx_pause;
      aggressive_backoff <= ctrl_one[BIT_AGGR_BO];
      age_tick           <= (age_state != AGE_OFF) && cnt_done;
      age_all            <= (age_state == AGE_FAST) && cnt_done && one_shot;
      entry_index        <= purge_index;
      entry_clear        <= purge_clear;
    end
  end

  property p_purge_ignored;
    @(posedge mclk) disable iff (reset)
      (purge_busy && wr_zero && purge_index != IDX_W'(TABLE_DEPTH - 1)) |=> purge_busy;
  endproperty
  a_purge_ignored: assert property (p_purge_ignored) else $error("purge restarted");

  property p_purge_starts;
    @(posedge mclk) disable iff (reset)
      purge_start |=> purge_busy ##31 purge_busy ##1 !purge_busy;
  endproperty
  a_purge_starts: assert property (p_purge_starts) else $error("purge length wrong");

  property p_conf_drop;
    @(posedge mclk) disable iff (reset)
      (frame_valid && conf_drop && frame_type_len == PAUSE_TYPE) |=> frame_drop;
  endproperty
  a_conf_drop: assert property (p_conf_drop) else $error("pause type not dropped");

  property p_pause_drop;
    @(posedge mclk) disable iff (reset)
      (frame_valid && !conf_drop && frame_is_pause) |=> frame_drop;
  endproperty
  a_pause_drop: assert property (p_pause_drop) else $error("pause frame kept");

  property p_tx_off;
    @(posedge mclk) disable iff (reset)
      tx_off |=> (tx_pause_en == '0);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx pause not forced off");

  property p_rx_follow;
    @(posedge mclk) disable iff (reset)
      !rx_off |=> (rx_pause_en == $past(an_rx_pause));
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx pause not following");

  property p_len_drop;
    @(posedge mclk) disable iff (reset)
      (frame_valid && len_check && frame_type_len < MAX_LEN_FIELD
       && frame_type_len != frame_payload_len) |=> frame_drop;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("bad length kept");

  property p_fast_age;
    @(posedge mclk) disable iff (reset)
      (age_en && fast_age && age_state == AGE_NORMAL) |=> (age_state == AGE_FAST);
  endproperty
  a_fast_age: assert property (p_fast_age) else $error("fast aging not entered");

  property p_age_off;
    @(posedge mclk) disable iff (reset)
      !age_en |=> (age_state == AGE_OFF) ##1 !age_tick;
  endproperty
  a_age_off: assert property (p_age_off) else $error("aging while disabled");

endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb
  import switch_global_control_pkg::*;
;
  localparam logic [11:0] CTL0 = ADDR_GLOBAL_CONTROL_ZERO_LOW;
  localparam logic [11:0] CTL1 = ADDR_GLOBAL_CONTROL_ONE;
  logic                 mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata;
  logic                 pause_strap, frame_valid, frame_is_pause, frame_drop;
  logic [NUM_PORTS-1:0] link_up, an_tx_pause, an_rx_pause, learn_disable;
  logic [NUM_PORTS-1:0] entry_ports, tx_pause_en, rx_pause_en;
  logic [47:0]          frame_da;
  logic [15:0]          frame_type_len, frame_payload_len, frame_total_len;
  logic                 entry_valid, entry_multicast, entry_clear;
  logic [IDX_W-1:0]     entry_index;
  logic                 aggressive_backoff, age_tick, age_all;
  int                   err_total, cmp_count, clr_cnt, tick_cnt, all_cnt, c0;

  switch_global_control #(.NORMAL_AGE(200), .FAST_AGE(20)) i_dut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pause_strap(pause_strap), .link_up(link_up),
    .an_tx_pause(an_tx_pause), .an_rx_pause(an_rx_pause),
    .learn_disable(learn_disable), .frame_valid(frame_valid), .frame_da(frame_da),
    .frame_type_len(frame_type_len), .frame_payload_len(frame_payload_len),
    .frame_total_len(frame_total_len), .frame_is_pause(frame_is_pause),
    .entry_valid(entry_valid), .entry_ports(entry_ports),
    .entry_multicast(entry_multicast), .entry_index(entry_index),
    .entry_clear(entry_clear), .frame_drop(frame_drop), .tx_pause_en(tx_pause_en),
    .rx_pause_en(rx_pause_en), .aggressive_backoff(aggressive_backoff),
    .age_tick(age_tick), .age_all(age_all));

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (entry_clear === 1'b1) clr_cnt <= clr_cnt + 1;
    if (age_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (age_all === 1'b1) all_cnt <= all_cnt + 1;
  end

  task automatic report_and_stop();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask

  task automatic send(input logic [15:0] tl, input logic [47:0] da,
                      input logic [15:0] pl, input logic [15:0] tot,
                      input logic isp, input logic exp);
    logic seen;
    @(posedge mclk);
    frame_valid <= 1'b1;
    frame_type_len <= tl;
    frame_da <= da;
    frame_payload_len <= pl;
    frame_total_len <= tot;
    frame_is_pause <= isp;
    @(posedge mclk);
    frame_valid <= 1'b0;
    @(posedge mclk);
    seen = frame_drop;
    @(posedge mclk);
    seen = seen | frame_drop;
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic purge(input logic [4:0] ports, input logic mc, input logic [4:0] ld,
                       input int exp);
    int          n, base;
    logic [31:0] r;
    logic        e;
    @(posedge mclk);
    entry_valid <= 1'b1;
    entry_ports <= ports;
    entry_multicast <= mc;
    learn_disable <= ld;
    base = clr_cnt;
    wr(CTL0, 32'h10);
    rdc(CTL0, 32'h1C);
    rdc(ADDR_STATUS, 32'h01);
    wr(CTL0, 32'h00);
    wr(CTL0, 32'h10);
    n = 0;
    do begin
      apb(1'b0, CTL0, 32'h0, r, e);
      n++;
    end while (r[4] === 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      report_and_stop();
    end
    check(r, 32'h0C);
    repeat (4) @(posedge mclk);
    check(32'(clr_cnt - base), 32'(exp));
  endtask

  task automatic ticks(input int len, input int lo, input int hi);
    int base;
    base = tick_cnt;
    repeat (len) @(posedge mclk);
    check(32'((tick_cnt - base >= lo) && (tick_cnt - base <= hi)), 32'h1);
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    mclk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pause_strap = 1; link_up = 5'h1F; an_tx_pause = 5'h15; an_rx_pause = 5'h0A;
    learn_disable = 0; frame_valid = 0; frame_da = 0; frame_type_len = 0;
    frame_payload_len = 0; frame_total_len = 0; frame_is_pause = 0;
    entry_valid = 0; entry_ports = 0; entry_multicast = 0;
    err_total = 0; cmp_count = 0; clr_cnt = 0; tick_cnt = 0; all_cnt = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(CTL0, 32'h0C);
    rdc(CTL1, 32'h34);
    check({27'h0, tx_pause_en | rx_pause_en}, 32'h0);
    wr(CTL1, 32'h14);
    repeat (3) @(posedge mclk);
    check({27'h0, tx_pause_en}, 32'h15);
    check({27'h0, rx_pause_en}, 32'h00);
    wr(CTL1, 32'h24);
    repeat (3) @(posedge mclk);
    check({27'h0, tx_pause_en}, 32'h00);
    check({27'h0, rx_pause_en}, 32'h0A);
    wr(CTL1, 32'h05);
    rdc(CTL1, 32'h05);
    check({31'h0, aggressive_backoff}, 32'h1);
    apb(1'b0, 12'h014, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    purge(5'h04, 1'b0, 5'h04, 32);
    purge(5'h04, 1'b0, 5'h00, 0);
    purge(5'h04, 1'b1, 5'h04, 0);
    purge(5'h06, 1'b0, 5'h06, 0);
    wr(CTL0, 32'h02);
    send(PAUSE_TYPE, 48'h020000000001, 16'h0040, 16'h0040, 1'b0, 1'b1);
    send(16'h0800, PAUSE_DA, 16'h0040, 16'h0040, 1'b0, 1'b1);
    send(16'h0800, 48'h020000000001, 16'h0040, 16'h0040, 1'b0, 1'b0);
    wr(CTL0, 32'h00);
    send(PAUSE_TYPE, 48'h020000000001, 16'h0040, 16'h0040, 1'b0, 1'b0);
    send(16'h0800, 48'h020000000001, 16'h0040, 16'h0040, 1'b1, 1'b1);
    wr(CTL1, 32'h0C);
    send(16'h0064, 48'h020000000001, 16'h0032, 16'h0040, 1'b0, 1'b1);
    send(16'h0064, 48'h020000000001, 16'h0064, 16'h0080, 1'b0, 1'b0);
    send(16'h05DC, 48'h020000000001, 16'h0010, 16'h0040, 1'b0, 1'b0);
    wr(CTL1, 32'h04);
    send(16'h0064, 48'h020000000001, 16'h0032, 16'h0040, 1'b0, 1'b0);
    send(16'h0800, 48'h020000000001, 16'h07B0, 16'h07D0, 1'b0, 1'b1);
    wr(CTL1, 32'h44);
    send(16'h0800, 48'h020000000001, 16'h07B0, 16'h07D0, 1'b0, 1'b0);
    wr(CTL1, 32'h04);
    repeat (220) @(posedge mclk);
    ticks(210, 1, 2);
    wr(CTL1, 32'h06);
    repeat (220) @(posedge mclk);
    ticks(210, 9, 11);
    wr(CTL1, 32'h00);
    repeat (30) @(posedge mclk);
    ticks(300, 0, 0);
    wr(CTL1, 32'h04);
    wr(CTL0, 32'h01);
    c0 = all_cnt;
    link_up <= 5'h1D;
    repeat (260) @(posedge mclk);
    check(32'(all_cnt - c0), 32'h1);
    ticks(210, 0, 2);
    link_up <= 5'h1F;
    wr(CTL0, 32'h00);
    repeat (10) @(posedge mclk);
    c0 = all_cnt;
    link_up <= 5'h1B;
    repeat (260) @(posedge mclk);
    check(32'(all_cnt - c0), 32'h0);
    report_and_stop();
  end
endmodule
